// ==== rtl/bcl_defs.svh ====
`ifndef BCL_DEFS_SVH
`define BCL_DEFS_SVH

// condition codes, low bit inverts the test
`define CC_OVERFLOW     4'h0
`define CC_BELOW        4'h2
`define CC_EQUAL        4'h4
`define CC_BELOW_EQUAL  4'h6
`define CC_SIGN         4'h8
`define CC_PARITY       4'ha
`define CC_LESS         4'hc
`define CC_LESS_EQUAL   4'he

// flag bit positions in the flags register
`define FLAG_CARRY      0
`define FLAG_PARITY     2
`define FLAG_ZERO       6
`define FLAG_SIGN       7
`define FLAG_OVERFLOW   11

// exception vectors
`define VEC_OVERFLOW    8'h04
`define VEC_RANGE       8'h05

// reset values
`define IP_RESET        64'h0000_0000_0000_0000
`define FLAGS_RESET     64'h0000_0000_0000_0002

// depth of the interrupt return stack
`define RET_DEPTH       16

`endif

// ==== rtl/bcl_pkg.sv ====
package bcl_pkg;

    // decoded operation kinds
    typedef enum logic [3:0] {
        op_none       = 4'h0,
        op_cond_jump  = 4'h1,
        op_count_zero = 4'h2,
        op_loop       = 4'h3,
        op_loop_eq    = 4'h4,
        op_loop_ne    = 4'h5,
        op_soft_int   = 4'h6,
        op_int_ovf    = 4'h7,
        op_range      = 4'h8,
        op_int_ret    = 4'h9
    } op_t;

    // address size selection
    typedef enum logic [1:0] {
        asz_16 = 2'h0,
        asz_32 = 2'h1,
        asz_64 = 2'h2
    } asz_t;

    // service sequencing states
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_push = 3'b010,
        st_pop  = 3'b100
    } state_t;

endpackage

// ==== rtl/ret_stack_mem.sv ====
`timescale 1ns/10ps

// =====================================================================
// return frame memory, registered read
module ret_stack_mem #(
    parameter int WIDTH = 128,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             mclk,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];    // frame storage

    // write port
    always_ff @(posedge mclk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // registered read port
    always_ff @(posedge mclk)
    begin
        rd_data <= mem[rd_addr];
    end

endmodule

// ==== rtl/branch_condition_loop_unit.sv ====
// Behaviour
// RULE1: above branches when carry and zero clear
// RULE2: carry clear or set selects branch
// RULE3: below-or-equal branches on carry or zero
// RULE4: single flag conditions and their negations
// RULE5: greater needs sign equal overflow, zero clear
// RULE6: signed compare by sign xor overflow
// RULE7: less-or-equal on xor or zero
// RULE8: not taken falls through, no return saved
// RULE9: target is pointer plus signed offset
// RULE10: paired names share one condition code
// RULE11: count-zero jump tests width-selected count
// RULE12: loop decrements count then branches nonzero
// RULE13: zero count wraps to all ones, branches
// RULE14: loop-equal needs nonzero count, zero set
// RULE15: loop-unequal needs nonzero count, zero clear
// RULE16: long mode forces 64-bit pointer update
// RULE17: displacement is 32-bit sign-extended
// RULE18: address size picks count width
// RULE19: soft interrupt raises immediate vector
// RULE20: overflow interrupt only when overflow set
// RULE21: range check raises out-of-bounds exception
// RULE22: interrupt service pushes flags and pointer
// RULE23: interrupt return restores flags and pointer
// RULE24: taken, next pointer, exception together
`timescale 1ns/10ps
`include "bcl_defs.svh"

module branch_condition_loop_unit #(
    parameter int DEPTH = `RET_DEPTH,
    parameter int AW    = 4
) (
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    input  wire logic                 op_valid,
    input  wire bcl_pkg::op_t         op_kind,
    input  wire logic [3:0]           cond_code,
    input  wire bcl_pkg::asz_t        addr_size,
    input  wire logic                 long_mode,
    input  wire logic [63:0]          instruction_pointer_64,
    input  wire logic [3:0]           instr_length,
    input  wire logic [31:0]          displacement,
    input  wire logic [7:0]           int_vector,
    input  wire logic [63:0]          flags_register,
    input  wire logic [63:0]          count_register_64,
    input  wire logic [31:0]          range_value,
    input  wire logic [31:0]          range_lower,
    input  wire logic [31:0]          range_upper,
    input  wire logic                 service_valid,
    input  wire logic [63:0]          service_target,
    output logic                      res_valid,
    output logic                      taken,
    output logic [63:0]               next_ip,
    output logic                      count_write,
    output logic [63:0]               count_next,
    output logic                      exc_req,
    output logic [7:0]                exc_vector,
    output logic                      flags_write,
    output logic [63:0]               flags_next,
    output logic                      busy,
    output logic                      stack_overflow
);
    import bcl_pkg::*;

    // =================================================================
    // condition evaluation
    // one encoding per condition pair, low bit inverts
    function automatic logic cond_true(input logic [3:0] cc, input logic [63:0] fl);
        logic cf;
        logic zf;
        logic sf;
        logic of_;
        logic pf;
        logic base;
        cf   = fl[`FLAG_CARRY];
        zf   = fl[`FLAG_ZERO];
        sf   = fl[`FLAG_SIGN];
        of_  = fl[`FLAG_OVERFLOW];
        pf   = fl[`FLAG_PARITY];
        base = 1'b0;
        unique case ({cc[3:1], 1'b0})                     // RULE10
            `CC_OVERFLOW:    base = of_;                   // RULE4
            `CC_BELOW:       base = cf;                    // RULE2
            `CC_EQUAL:       base = zf;                    // RULE4
            `CC_BELOW_EQUAL: base = cf | zf;               // RULE1 RULE3
            `CC_SIGN:        base = sf;                    // RULE4
            `CC_PARITY:      base = pf;                    // RULE4
            `CC_LESS:        base = sf ^ of_;              // RULE6
            `CC_LESS_EQUAL:  base = (sf ^ of_) | zf;       // RULE5 RULE7
            default:         base = 1'b0;
        endcase
        return base ^ cc[0];
    endfunction

    // count width masking, reused for test and decrement
    function automatic logic [63:0] count_mask(input asz_t asz, input logic lm);
        logic [63:0] m;
        m = 64'hffff_ffff_ffff_ffff;
        unique case (asz)
            asz_16:  m = 64'h0000_0000_0000_ffff;
            asz_32:  m = 64'h0000_0000_ffff_ffff;
            default: m = lm ? 64'hffff_ffff_ffff_ffff : 64'h0000_0000_ffff_ffff;
        endcase
        return m;
    endfunction

    // =================================================================
    // combinational datapath
    logic [63:0] mask;          // active count bits
    logic [63:0] cnt_cur;       // count at selected width
    logic [63:0] cnt_dec;       // decremented count, wrapped
    logic [63:0] cnt_merged;    // decrement merged into full register
    logic        dec_nonzero;   // decremented count is nonzero
    logic [63:0] seq_ip;        // next sequential pointer
    logic [63:0] rel_ip;        // relative target
    logic [63:0] ip_mask;       // pointer width
    logic        range_bad;     // value outside bounds

    assign mask        = count_mask(addr_size, long_mode);                // RULE18
    assign cnt_cur     = count_register_64 & mask;                        // RULE11
    assign cnt_dec     = (cnt_cur - 64'h1) & mask;                        // RULE12 RULE13
    assign cnt_merged  = (count_register_64 & ~mask) | cnt_dec;
    assign dec_nonzero = (cnt_dec != 64'h0);
    assign ip_mask     = long_mode ? 64'hffff_ffff_ffff_ffff
                                   : 64'h0000_0000_ffff_ffff;             // RULE16
    assign seq_ip      = (instruction_pointer_64 + {60'h0, instr_length}) & ip_mask;
    assign rel_ip      = (seq_ip + {{32{displacement[31]}}, displacement})
                         & ip_mask;                                       // RULE9 RULE17
    assign range_bad   = ($signed(range_value) < $signed(range_lower))
                       | ($signed(range_value) > $signed(range_upper));   // RULE21

    // branch decision per operation
    logic branch_d;
    always_comb
    begin
        branch_d = 1'b0;
        unique case (op_kind)
            op_cond_jump:  branch_d = cond_true(cond_code, flags_register);
            op_count_zero: branch_d = (cnt_cur == 64'h0);                     // RULE11
            op_loop:       branch_d = dec_nonzero;                            // RULE12 RULE13
            op_loop_eq:    branch_d = dec_nonzero & flags_register[`FLAG_ZERO];  // RULE14
            op_loop_ne:    branch_d = dec_nonzero & ~flags_register[`FLAG_ZERO]; // RULE15
            default:       branch_d = 1'b0;
        endcase
    end

    logic is_loop;
    assign is_loop = (op_kind == op_loop) | (op_kind == op_loop_eq) | (op_kind == op_loop_ne);

    // =================================================================
    // interrupt return frame stack
    state_t       state_q;
    logic [AW:0]  sp_q;          // frames held
    logic         mem_wr;
    logic [AW-1:0] mem_waddr;
    logic [AW-1:0] mem_raddr;
    logic [127:0] mem_rdata;
    logic         take_int;      // an interrupt or exception is being raised
    logic         start_ret;     // interrupt return accepted

    assign take_int  = op_valid & (state_q == st_idle) & (
                       (op_kind == op_soft_int)
                     | ((op_kind == op_int_ovf) & flags_register[`FLAG_OVERFLOW])
                     | ((op_kind == op_range) & range_bad));
    assign start_ret = op_valid & (state_q == st_idle) & (op_kind == op_int_ret)
                     & (sp_q != '0);
    assign mem_wr    = (take_int | service_valid) & (sp_q != DEPTH[AW:0]);
    assign mem_waddr = sp_q[AW-1:0];
    assign mem_raddr = sp_q[AW-1:0] - {{(AW-1){1'b0}}, 1'b1};

    // frame: flags high, return pointer low
    ret_stack_mem #(
        .WIDTH (128),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_frames (
        .mclk    (mclk),
        .wr_en   (mem_wr),
        .wr_addr (mem_waddr),
        .wr_data ({flags_register, seq_ip}),   // RULE22
        .rd_addr (mem_raddr),
        .rd_data (mem_rdata)
    );

    // stack pointer
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            sp_q <= '0;
        end
        else if (mem_wr)
        begin
            sp_q <= sp_q + {{AW{1'b0}}, 1'b1};     // RULE22
        end
        else if (start_ret)
        begin
            sp_q <= sp_q - {{AW{1'b0}}, 1'b1};
        end
    end

    // sequencing: pop needs a cycle for registered read
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            state_q <= st_idle;
        end
        else
        begin
            unique case (state_q)
                st_idle: state_q <= start_ret ? st_pop : st_idle;
                st_push: state_q <= st_idle;
                st_pop:  state_q <= st_idle;
                default: state_q <= st_idle;
            endcase
        end
    end

    // =================================================================
    // result outputs
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            res_valid <= 1'b0;
            taken     <= 1'b0;
            next_ip   <= `IP_RESET;
            exc_req   <= 1'b0;
            exc_vector <= 8'h00;
        end
        else if (state_q == st_pop)
        begin
            res_valid <= 1'b1;                            // RULE23
            taken     <= 1'b1;
            next_ip   <= mem_rdata[63:0];                 // RULE23
            exc_req   <= 1'b0;
            exc_vector <= 8'h00;
        end
        else if (op_valid && state_q == st_idle && op_kind != op_int_ret)
        begin
            res_valid <= 1'b1;                            // RULE24
            taken     <= branch_d;
            next_ip   <= branch_d ? rel_ip : seq_ip;      // RULE8 RULE24
            exc_req   <= take_int;                        // RULE19 RULE20 RULE21
            unique case (op_kind)
                op_soft_int: exc_vector <= int_vector;    // RULE19
                op_int_ovf:  exc_vector <= `VEC_OVERFLOW; // RULE20
                op_range:    exc_vector <= `VEC_RANGE;    // RULE21
                default:     exc_vector <= 8'h00;
            endcase
        end
        else if (service_valid)
        begin
            res_valid <= 1'b1;
            taken     <= 1'b1;
            next_ip   <= service_target & ip_mask;        // RULE16
            exc_req   <= 1'b0;
            exc_vector <= 8'h00;
        end
        else
        begin
            res_valid <= 1'b0;
            taken     <= 1'b0;
            exc_req   <= 1'b0;
        end
    end

    // count writeback for loop operations
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            count_write <= 1'b0;
            count_next  <= 64'h0;
        end
        else
        begin
            count_write <= op_valid & (state_q == st_idle) & is_loop;   // RULE12
            count_next  <= cnt_merged;
        end
    end

    // flags writeback on interrupt return
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            flags_write <= 1'b0;
            flags_next  <= `FLAGS_RESET;
        end
        else
        begin
            flags_write <= (state_q == st_pop);                  // RULE23
            flags_next  <= (state_q == st_pop) ? mem_rdata[127:64] : flags_next;
        end
    end

    // status
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            busy           <= 1'b0;
            stack_overflow <= 1'b0;
        end
        else
        begin
            busy           <= start_ret;
            stack_overflow <= (take_int | service_valid) & (sp_q == DEPTH[AW:0]);
        end
    end

endmodule

// ==== verif/bcl_asserts.sv ====
`timescale 1ns/10ps
// ==========================================
// port checks for the branch unit
module bcl_asserts
    import bcl_pkg::*;
(
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        op_valid,
    input wire op_t         op_kind,
    input wire logic [3:0]  cond_code,
    input wire logic [63:0] flags_register,
    input wire logic [7:0]  int_vector,
    input wire logic        service_valid,
    input wire logic        res_valid,
    input wire logic        taken,
    input wire logic        count_write,
    input wire logic        exc_req,
    input wire logic [7:0]  exc_vector,
    input wire logic        flags_write,
    input wire logic        busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // accepted op of one kind
    sequence s_op(op_t k);
        op_valid && !busy && op_kind == k;
    endsequence
    // accepted conditional jump with one code
    sequence s_jcc(logic [3:0] c);
        s_op(op_cond_jump) ##0 cond_code == c;
    endsequence
    AST_ABOVE: assert property (s_jcc(4'h7) |=>
        taken == !($past(flags_register[0]) | $past(flags_register[6])))
        else $error("above decision wrong");
    AST_EQUAL: assert property (s_jcc(4'h4) |=>
        taken == $past(flags_register[6])) else $error("equal decision wrong");
    AST_GREATER: assert property (s_jcc(4'hf) |=>
        taken == ($past(flags_register[7]) == $past(flags_register[11])
        && !$past(flags_register[6]))) else $error("greater decision wrong");
    AST_INTO: assert property (s_op(op_int_ovf) |=>
        res_valid && exc_req == $past(flags_register[11]))
        else $error("overflow trap wrong");
    AST_SOFT: assert property (s_op(op_soft_int) |=>
        exc_req && !taken && exc_vector == $past(int_vector))
        else $error("soft interrupt wrong");
    AST_LOOP: assert property (op_valid && !busy
        && op_kind inside {op_loop, op_loop_eq, op_loop_ne} |=> res_valid && count_write)
        else $error("loop count not written");
    AST_RET: assert property (busy |=> res_valid && taken && flags_write)
        else $error("return not completed");
    AST_RESULT: assert property (res_valid |->
        $past(op_valid) || $past(busy) || $past(service_valid))
        else $error("result without cause");
    AST_FLAGW: assert property (flags_write |-> $past(busy))
        else $error("flags written outside return");
endmodule

bind branch_condition_loop_unit bcl_asserts bcl_asserts_i (.mclk, .nrst, .op_valid,
    .op_kind, .cond_code, .flags_register, .int_vector, .service_valid, .res_valid,
    .taken, .count_write, .exc_req, .exc_vector, .flags_write, .busy);

// ==== verif/bcl_dispatch_model.sv ====
`timescale 1ns/10ps
// ==========================================
// exception dispatch: services a request later
module bcl_dispatch_model #(
    parameter logic [63:0] TARGET = 64'h0000_0000_0000_8000
) (
    input wire logic   mclk,
    input wire logic   nrst,
    input wire logic   en,
    input wire logic   exc_req,
    output logic       service_valid,
    output logic [63:0] service_target
);
    logic [1:0] cnt_q; // cycles until service
    // one pulse three cycles after a request
    always_ff @(posedge mclk)
    begin
        if (!nrst || !en)
        begin
            cnt_q <= 2'h0;
            service_valid <= 1'b0;
        end
        else
        begin
            service_valid <= (cnt_q == 2'h1);
            if (exc_req)
                cnt_q <= 2'h2;
            else if (cnt_q != 2'h0)
                cnt_q <= cnt_q - 2'h1;
        end
    end
    assign service_target = TARGET;
endmodule

// ==== verif/branch_condition_loop_unit_bench.sv ====
`timescale 1ns/10ps
// ==========================================
// bench top
module branch_condition_loop_unit_bench;
    import bcl_pkg::*;
    localparam logic [63:0] SEQ = 64'h1_0000_0012; // fall-through pointer
    localparam logic [63:0] TGT = 64'h1_0000_0002; // pointer + 2 - 16
    logic mclk, nrst, op_valid, long_mode, service_valid, part_en;
    op_t op_kind;
    asz_t addr_size;
    logic [3:0] cond_code, instr_length;
    logic [7:0] int_vector, exc_vector;
    logic [31:0] displacement, range_value, range_lower, range_upper;
    logic [63:0] instruction_pointer_64, flags_register, count_register_64;
    logic [63:0] service_target, next_ip, count_next, flags_next;
    logic res_valid, taken, count_write, exc_req, flags_write, busy, stack_overflow;
    int error_cnt, cmp_count;

    branch_condition_loop_unit branch_condition_loop_unit_i (.mclk, .nrst, .op_valid,
        .op_kind, .cond_code, .addr_size, .long_mode, .instruction_pointer_64,
        .instr_length, .displacement, .int_vector, .flags_register, .count_register_64,
        .range_value, .range_lower, .range_upper, .service_valid, .service_target,
        .res_valid, .taken, .next_ip, .count_write, .count_next, .exc_req, .exc_vector,
        .flags_write, .flags_next, .busy, .stack_overflow);
    bcl_dispatch_model bcl_dispatch_model_i (.mclk, .nrst, .en(part_en), .exc_req,
        .service_valid, .service_target);

    // ==========================================
    // helpers
    task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one op pulse, returns once a non-return op's result has landed
    task issue(input op_t k);
        @(posedge mclk);
        #1;
        op_valid = 1'b1;
        op_kind = k;
        @(posedge mclk);
        #1;
        op_valid = 1'b0;
    endtask
    // expected decision per condition code
    function logic cexp(input logic [3:0] c, input logic [63:0] f);
        logic r;
        case (c[3:1])
            3'h0: r = f[11];
            3'h1: r = f[0];
            3'h2: r = f[6];
            3'h3: r = f[0] | f[6];
            3'h4: r = f[7];
            3'h5: r = f[2];
            3'h6: r = f[7] ^ f[11];
            default: r = (f[7] ^ f[11]) | f[6];
        endcase
        return r ^ c[0];
    endfunction
    // loop or count-zero op with expected decision and count
    task lp(input op_t k, input asz_t a, input logic [63:0] cnt, input logic zf,
            input logic t, input logic [63:0] c);
        count_register_64 = cnt;
        addr_size = a;
        flags_register = {57'h0, zf, 6'h02};
        issue(k);
        chk("loop taken", 64'(t), 64'(taken));
        chk("loop next_ip", t ? TGT : SEQ, next_ip);
        chk("count_write", 64'(k != op_count_zero), 64'(count_write));
        if (k != op_count_zero)
            chk("count_next", c, count_next);
    endtask
    // exception op with expected request and vector
    task ex(input op_t k, input logic [63:0] f, input logic [31:0] v, input logic e,
            input logic [7:0] vec);
        flags_register = f;
        range_value = v;
        issue(k);
        chk("exc_req", 64'(e), 64'(exc_req));
        if (e)
            chk("exc_vector", 64'(vec), 64'(exc_vector));
    endtask
    // interrupt return, bounded wait for its result
    task rt(input logic ck_ip, input logic [63:0] f);
        issue(op_int_ret);
        chk("ret busy", 64'h1, 64'(busy));
        for (int n = 0; n < 4 && res_valid !== 1'b1; n++)
        begin
            @(posedge mclk);
            #1;
        end
        chk("ret res_valid", 64'h1, 64'(res_valid));
        chk("ret flags_write", 64'h1, 64'(flags_write));
        chk("flags_next", f, flags_next);
        if (ck_ip)
            chk("ret next_ip", SEQ, next_ip);
    endtask
    task results();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ==========================================
    // clock, watchdog
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        results();
    end

    // ==========================================
    // main sequence
    initial
    begin
        error_cnt = 0;
        cmp_count = 0;
        nrst = 1'b0;
        op_valid = 1'b0;
        op_kind = op_none;
        part_en = 1'b0;
        cond_code = 4'h0;
        addr_size = asz_64;
        long_mode = 1'b1;
        instruction_pointer_64 = 64'h1_0000_0010;
        instr_length = 4'h2;
        displacement = 32'hffff_fff0;
        int_vector = 8'h21;
        flags_register = 64'h2;
        count_register_64 = 64'h0;
        range_value = 32'h0;
        range_lower = 32'hffff_fffe;
        range_upper = 32'h5;
        repeat (8) @(posedge mclk);
        #1;
        nrst = 1'b1;
        for (int c = 0; c < 16; c++)
            for (int i = 0; i < 32; i++)
            begin
                cond_code = c[3:0];
                flags_register = {52'h0, i[4], 3'h0, i[3], i[2], 3'h0, i[1], 1'b1, i[0]};
                issue(op_cond_jump);
                chk("taken", 64'(cexp(cond_code, flags_register)), 64'(taken));
                chk("next_ip", cexp(cond_code, flags_register) ? TGT : SEQ, next_ip);
                chk("jump count_write", 64'h0, 64'(count_write));
            end
        issue(op_int_ret);
        @(posedge mclk);
        #1;
        chk("empty ret res_valid", 64'h0, 64'(res_valid));
        lp(op_loop, asz_32, 64'h5_0000_0000, 1'b0, 1'b1, 64'h5_ffff_ffff);
        lp(op_loop, asz_16, 64'h3_0001, 1'b0, 1'b0, 64'h3_0000);
        lp(op_loop, asz_64, 64'h1_0000_0000, 1'b0, 1'b1, 64'hffff_ffff);
        lp(op_loop_eq, asz_64, 64'h3, 1'b1, 1'b1, 64'h2);
        lp(op_loop_eq, asz_64, 64'h3, 1'b0, 1'b0, 64'h2);
        lp(op_loop_eq, asz_64, 64'h1, 1'b1, 1'b0, 64'h0);
        lp(op_loop_ne, asz_64, 64'h3, 1'b0, 1'b1, 64'h2);
        lp(op_loop_ne, asz_64, 64'h3, 1'b1, 1'b0, 64'h2);
        lp(op_count_zero, asz_16, 64'h1_0000, 1'b0, 1'b1, 64'h0);
        lp(op_count_zero, asz_32, 64'h1_0000, 1'b0, 1'b0, 64'h0);
        // outside long mode: 64-bit size acts as 32, pointer truncated
        long_mode = 1'b0;
        count_register_64 = 64'h7_0000_0000;
        addr_size = asz_64;
        issue(op_loop);
        chk("legacy taken", 64'h1, 64'(taken));
        chk("legacy next_ip", TGT & 64'hffff_ffff, next_ip);
        chk("legacy count_next", 64'h7_ffff_ffff, count_next);
        long_mode = 1'b1;
        ex(op_int_ovf, 64'h802, 32'h0, 1'b1, 8'h04);
        ex(op_int_ovf, 64'h2, 32'h0, 1'b0, 8'h00);
        ex(op_range, 64'h2, 32'h6, 1'b1, 8'h05);
        ex(op_range, 64'h2, 32'hffff_fffd, 1'b1, 8'h05);
        ex(op_range, 64'h2, 32'hffff_fffe, 1'b0, 8'h00);
        ex(op_range, 64'h2, 32'h5, 1'b0, 8'h00);
        part_en = 1'b1;
        ex(op_soft_int, 64'h8c3, 32'h0, 1'b1, 8'h21);
        repeat (6) @(posedge mclk);
        #1;
        part_en = 1'b0;
        chk("service next_ip", 64'h8000, next_ip);
        rt(1'b0, 64'h8c3);
        rt(1'b1, 64'h8c3);
        // three frames left: thirteen more fill it, the next is dropped
        for (int n = 0; n < 14; n++)
            ex(op_soft_int, 64'h2, 32'h0, 1'b1, 8'h21);
        chk("stack_overflow", 64'h1, 64'(stack_overflow));
        results();
    end
endmodule
